// ---- fac_pkg.sv ----
/*
  Constants shared by the flash command issue controller: the device register map
  as the controller sees it, the command and area codes, the security flag bit
  positions, the controller's own software register map and its state type.
  Assumes a tool that accepts packed structs with enum members.
*/
`default_nettype none
package fac_pkg;
  // Device register indices on the device register port
  localparam logic [3:0] DEV_AREA_SEL   = 4'h0;
  localparam logic [3:0] DEV_ADDR_LO    = 4'h1;
  localparam logic [3:0] DEV_ADDR_HI    = 4'h2;
  localparam logic [3:0] DEV_WDATA_LO   = 4'h3;
  localparam logic [3:0] DEV_WDATA_HI   = 4'h4;
  localparam logic [3:0] DEV_MAIN_CMD   = 4'h5;
  localparam logic [3:0] DEV_END_LO     = 4'h6;
  localparam logic [3:0] DEV_END_HI     = 4'h7;
  localparam logic [3:0] DEV_EXTRA_CMD  = 4'h8;
  localparam logic [3:0] DEV_SEC_FLAGS  = 4'h9;
  // Device values
  localparam logic [15:0] AREA_USER     = 16'h0000;
  localparam logic [15:0] AREA_EXTRA    = 16'h0001;
  localparam logic [15:0] CMD_PROGRAM   = 16'h0081;
  localparam logic [15:0] CMD_BLANK_DF  = 16'h008B;
  localparam logic [15:0] CMD_SECURITY  = 16'h0087;
  localparam logic [15:0] WDATA_HI_ONES = 16'hFFFF;
  localparam int          BOOT_BIT      = 8;
  localparam int          ERASE_BIT     = 10;
  localparam int          PROG_BIT      = 12;
  localparam logic [23:0] BLOCK_LAST    = 24'h0000FF;
  // Controller register byte offsets
  localparam logic [3:0] REG_CMD        = 4'h0;
  localparam logic [3:0] REG_ADDR       = 4'h4;
  localparam logic [3:0] REG_DATA       = 4'h8;
  localparam logic [3:0] REG_STATUS     = 4'hC;
  localparam int          CMD_START_BIT = 0;
  localparam int          CMD_OP_LSB    = 4;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_DONE_BIT   = 1;
  localparam int          ST_REFUSE_BIT = 2;
  localparam int          ST_DEVERR_BIT = 3;
  localparam int          ST_SEC_LSB    = 16;
  // Operations and AXI response codes
  localparam logic [1:0] OP_PROG        = 2'h0;
  localparam logic [1:0] OP_BLANK       = 2'h1;
  localparam logic [1:0] OP_ERASE_PROT  = 2'h2;
  localparam logic [1:0] OP_WRITE_PROT  = 2'h3;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_STEP, ST_WAIT_HI, ST_WAIT_LO
  } fac_state_t;

  typedef struct packed {
    logic        we;
    logic        last;
    logic [3:0]  addr;
    logic [15:0] data;
  } fac_step_t;
endpackage
`default_nettype wire

// ---- fac_ctrl.sv ----
/*
  Flash command issue controller: takes orders over an AXI4-Lite slave and
  drives the flash sequencer's registers through a request/acknowledge register
  port, then polls the sequencer busy lines for completion.
  Assumes the device port and status lines are synchronous to i_clk.
*/
`default_nettype none
module fac_ctrl
  import fac_pkg::*;
#(
  parameter logic [6:0]  DF_BLOCKS = 7'd64,
  parameter logic [23:0] DF_BASE   = 24'h000000
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [3:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_dev_req,
  output logic             o_dev_we,
  output logic [3:0]       o_dev_addr,
  output logic [15:0]      o_dev_wdata,
  input  wire logic        i_dev_ack,
  input  wire logic [15:0] i_dev_rdata,
  input  wire logic        i_dataflash_access_en,
  input  wire logic        i_df_prog_mode,
  input  wire logic        i_cf_prog_mode,
  input  wire logic        i_main_busy,
  input  wire logic        i_extra_busy,
  input  wire logic        i_main_err,
  input  wire logic        i_extra_err
);

  typedef struct packed {
    fac_state_t  state;
    logic [2:0]  step;
    logic [1:0]  op;
    logic [23:0] addr;
    logic [7:0]  data;
    logic [15:0] sec;
    logic        done;
    logic        refused;
    logic        dev_err;
    logic        dev_req;
    logic        dev_we;
    logic [3:0]  dev_addr;
    logic [15:0] dev_wdata;
    logic        awready;
    logic        wready;
    logic [3:0]  aw_addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } fac_regs_t;

  fac_regs_t r;
  fac_regs_t next_r;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Register access sequence of each operation, one entry per step
  function automatic fac_step_t step_word(input logic [1:0] op, input logic [2:0] step,
                                          input logic [23:0] a, input logic [7:0] d,
                                          input logic [15:0] sec);
    logic [23:0] s;
    logic [23:0] e;
    logic [15:0] mask;
    fac_step_t   w;
    s    = DF_BASE + {10'h000, a[5:0], 8'h00};
    e    = s + BLOCK_LAST;
    mask = (op == OP_ERASE_PROT) ? (16'h0001 << ERASE_BIT) : (16'h0001 << PROG_BIT);
    w    = '{we: 1'b1, last: 1'b0, addr: DEV_AREA_SEL, data: AREA_USER};
    case (op)
      OP_PROG: begin
        case (step)
          3'd0: w.data = AREA_USER;
          3'd1: w = '{1'b1, 1'b0, DEV_ADDR_LO, a[15:0]};
          3'd2: w = '{1'b1, 1'b0, DEV_ADDR_HI, {8'h00, a[23:16]}};
          3'd3: w = '{1'b1, 1'b0, DEV_WDATA_LO, {8'h00, d}};
          default: w = '{1'b1, 1'b1, DEV_MAIN_CMD, CMD_PROGRAM};
        endcase
      end
      OP_BLANK: begin
        case (step)
          3'd0: w.data = AREA_USER;
          3'd1: w = '{1'b1, 1'b0, DEV_ADDR_LO, s[15:0]};
          3'd2: w = '{1'b1, 1'b0, DEV_ADDR_HI, {8'h00, s[23:16]}};
          3'd3: w = '{1'b1, 1'b0, DEV_END_LO, e[15:0]};
          3'd4: w = '{1'b1, 1'b0, DEV_END_HI, {8'h00, e[23:16]}};
          default: w = '{1'b1, 1'b1, DEV_MAIN_CMD, CMD_BLANK_DF};
        endcase
      end
      default: begin
        case (step)
          3'd0: w.data = AREA_EXTRA;
          3'd1: w = '{1'b0, 1'b0, DEV_SEC_FLAGS, 16'h0000};
          3'd2: w = '{1'b1, 1'b0, DEV_WDATA_LO, sec & ~mask};
          3'd3: w = '{1'b1, 1'b0, DEV_WDATA_HI, WDATA_HI_ONES};
          default: w = '{1'b1, 1'b1, DEV_EXTRA_CMD, CMD_SECURITY};
        endcase
      end
    endcase
    return w;
  endfunction

  fac_step_t   cur;
  logic        busy_sel;
  logic        range_ok;
  logic        mode_ok;
  logic [23:0] prog_off;
  logic [31:0] status;
  logic [31:0] cmd_word;

  always_comb begin
    cur      = step_word(r.op, r.step, r.addr, r.data, r.sec);
    busy_sel = (r.op[1] == 1'b0) ? i_main_busy : i_extra_busy;
    prog_off = r.addr - DF_BASE;
    range_ok = 1'b1;
    if (r.op == OP_PROG) begin
      range_ok = (r.addr >= DF_BASE) && (prog_off[23:8] < {9'h000, DF_BLOCKS});
    end else if (r.op == OP_BLANK) begin
      range_ok = (r.addr[23:6] == 18'h00000) && ({1'b0, r.addr[5:0]} < DF_BLOCKS);
    end
    if (r.op[1] == 1'b0) begin
      mode_ok = i_df_prog_mode;
    end else begin
      mode_ok = i_cf_prog_mode;
    end
    status = 32'h00000000;
    status[ST_BUSY_BIT]   = (r.state != ST_IDLE);
    status[ST_DONE_BIT]   = r.done;
    status[ST_REFUSE_BIT] = r.refused;
    status[ST_DEVERR_BIT] = r.dev_err;
    status[ST_SEC_LSB +: 16] = r.sec;
    cmd_word = 32'h00000000;
    cmd_word[CMD_OP_LSB +: 2] = r.op;
  end

  always_comb begin
    next_r = r;
    // Write channel: address and data taken in either order
    if (i_awvalid && r.awready) begin
      next_r.awready = 1'b0;
      next_r.aw_addr = i_awaddr;
    end
    if (i_wvalid && r.wready) begin
      next_r.wready = 1'b0;
      next_r.wdata  = i_wdata;
      next_r.wstrb  = i_wstrb;
    end
    if (!r.awready && !r.wready && !r.bvalid) begin
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      case (r.aw_addr)
        REG_CMD: begin
          if (r.wstrb[0] && r.wdata[CMD_START_BIT] && (r.state == ST_IDLE)) begin
            next_r.op      = r.wdata[CMD_OP_LSB +: 2];
            next_r.state   = ST_CHECK;
            next_r.step    = 3'd0;
            next_r.done    = 1'b0;
            next_r.refused = 1'b0;
            next_r.dev_err = 1'b0;
          end
        end
        REG_ADDR: begin
          if (r.state == ST_IDLE) begin
            next_r.addr = 24'(merge({8'h00, r.addr}, r.wdata, r.wstrb));
          end
        end
        REG_DATA: begin
          if ((r.state == ST_IDLE) && r.wstrb[0]) begin
            next_r.data = r.wdata[7:0];
          end
        end
        REG_STATUS: ;
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && i_bready) begin
      next_r.bvalid  = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready  = 1'b1;
    end
    // Read channel
    if (i_arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = RESP_OKAY;
      case (i_araddr)
        REG_CMD:    next_r.rdata = cmd_word;
        REG_ADDR:   next_r.rdata = {8'h00, r.addr};
        REG_DATA:   next_r.rdata = {24'h000000, r.data};
        REG_STATUS: next_r.rdata = status;
        default: begin
          next_r.rdata = 32'h00000000;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (r.rvalid && i_rready) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end
    // Command sequence
    case (r.state)
      ST_IDLE: ;
      ST_CHECK: begin
        if (i_dataflash_access_en && mode_ok && range_ok
            && !i_main_busy && !i_extra_busy) begin
          next_r.state = ST_STEP;
        end else begin
          next_r.state   = ST_IDLE;
          next_r.refused = 1'b1;
          next_r.done    = 1'b1;
        end
      end
      ST_STEP: begin
        if (!r.dev_req) begin
          next_r.dev_req   = 1'b1;
          next_r.dev_we    = cur.we;
          next_r.dev_addr  = cur.addr;
          next_r.dev_wdata = cur.data;
        end else if (i_dev_ack) begin
          next_r.dev_req = 1'b0;
          if (!r.dev_we) begin
            next_r.sec = i_dev_rdata;
          end
          if (cur.last) begin
            next_r.state = ST_WAIT_HI;
          end else begin
            next_r.step = r.step + 3'd1;
          end
        end
      end
      ST_WAIT_HI: begin
        if (busy_sel) begin
          next_r.state = ST_WAIT_LO;
        end
      end
      ST_WAIT_LO: begin
        if (!busy_sel) begin
          next_r.state   = ST_IDLE;
          next_r.done    = 1'b1;
          next_r.dev_err = (r.op[1] == 1'b0) ? i_main_err : i_extra_err;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r         <= '0;
      r.state   <= ST_IDLE;
      r.awready <= 1'b1;
      r.wready  <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_awready   = r.awready;
  assign o_wready    = r.wready;
  assign o_bvalid    = r.bvalid;
  assign o_bresp     = r.bresp;
  assign o_arready   = r.arready;
  assign o_rvalid    = r.rvalid;
  assign o_rdata     = r.rdata;
  assign o_rresp     = r.rresp;
  assign o_dev_req   = r.dev_req;
  assign o_dev_we    = r.dev_we;
  assign o_dev_addr  = r.dev_addr;
  assign o_dev_wdata = r.dev_wdata;

  wire dev_wr = r.dev_req && r.dev_we;

  req_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    r.dev_req && !i_dev_ack |=> r.dev_req && $stable(r.dev_addr) && $stable(r.dev_wdata))
    else $error("device request dropped or changed before ack");
  area_code_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_AREA_SEL) |-> r.dev_wdata == (r.op[1] ? AREA_EXTRA : AREA_USER))
    else $error("wrong area select value");
  main_cmd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_MAIN_CMD) |->
      r.dev_wdata == ((r.op == OP_PROG) ? CMD_PROGRAM : CMD_BLANK_DF) && !r.op[1])
    else $error("wrong main sequencer start code");
  prog_byte_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_WDATA_LO) && (r.op == OP_PROG) |->
      r.dev_wdata == {8'h00, r.data})
    else $error("program byte not in low bits");
  addr_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_ADDR_HI) |-> r.dev_wdata[15:8] == 8'h00)
    else $error("address upper bits not zero");
  sec_copy_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_WDATA_LO) && r.op[1] |->
      r.dev_wdata[BOOT_BIT] == r.sec[BOOT_BIT] &&
      !r.dev_wdata[(r.op == OP_ERASE_PROT) ? ERASE_BIT : PROG_BIT])
    else $error("security flag image wrong");
  high_ones_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_WDATA_HI) |-> r.dev_wdata == WDATA_HI_ONES)
    else $error("high write data not all ones");
  extra_cmd_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_EXTRA_CMD) |-> r.dev_wdata == CMD_SECURITY && r.op[1])
    else $error("wrong extra sequencer start code");
  refuse_path_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (r.state == ST_CHECK) && (!i_dataflash_access_en || i_main_busy || i_extra_busy) |=>
      (r.state == ST_IDLE) && r.refused && r.done && !r.dev_req)
    else $error("precondition failure not refused");
  done_seen_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (r.state == ST_WAIT_LO) && !busy_sel |=> r.done && (r.state == ST_IDLE))
    else $error("completion not reported");
  range_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (r.state == ST_CHECK) && !range_ok |=> (r.state == ST_IDLE) && r.refused)
    else $error("out of range command not refused");
  mode_refuse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (r.state == ST_CHECK) && !mode_ok |=> (r.state == ST_IDLE) && r.refused)
    else $error("wrong mode command not refused");
  blank_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    dev_wr && (r.dev_addr == DEV_END_LO) |->
      (r.dev_wdata[7:0] == 8'(DF_BASE[7:0] + 8'hFF)) && (r.op == OP_BLANK))
    else $error("blank check end address wrong");
  sec_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    r.dev_req && !r.dev_we |-> (r.dev_addr == DEV_SEC_FLAGS) && r.op[1])
    else $error("unexpected device register read");

endmodule
`default_nettype wire

// ---- fac_dev_model.sv ----
/*
  Behavioural flash sequencer on the controller's device register port: register
  file, security flag source and two sequencers that stay busy for a while.
  Assumes the request/acknowledge port of fac_ctrl, synchronous to i_clk.
*/
`default_nettype none
module fac_dev_model
  import fac_pkg::*;
#(
  parameter int BUSY_LEN = 5
) (
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic             o_main_busy,
  output logic             o_extra_busy,
  output logic             o_main_err,
  output logic             o_extra_err,
  input  wire logic        i_slow,
  input  wire logic        i_err_inj,
  input  wire logic [15:0] i_sec_init
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [0:15];
  logic [15:0] rd;
  logic [2:0]  dly;
  int          main_cnt;
  int          extra_cnt;
  logic        err;
  // Outside the ack cycle the data lines never show the last value
  assign o_rdata      = o_ack ? rd : ~rd;
  assign o_main_busy  = (main_cnt != 0);
  assign o_extra_busy = (extra_cnt != 0);
  assign o_main_err   = err;
  assign o_extra_err  = err;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack <= 1'b0;
      rd <= 16'h0000;
      dly <= 3'h0;
      main_cnt <= 0;
      extra_cnt <= 0;
      err <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      if (main_cnt != 0) main_cnt <= main_cnt - 1;
      if (extra_cnt != 0) extra_cnt <= extra_cnt - 1;
      if (i_req && !o_ack) begin
        if (dly < (i_slow ? 3'h3 : 3'h0)) begin
          dly <= dly + 3'h1;
        end else begin
          o_ack <= 1'b1;
          dly <= 3'h0;
          rd <= (i_addr == DEV_SEC_FLAGS) ? i_sec_init : regs[i_addr];
          if (i_we) regs[i_addr] <= i_wdata;
          if (i_we && i_wdata[7] && (i_addr == DEV_MAIN_CMD || i_addr == DEV_EXTRA_CMD)) begin
            if (i_addr == DEV_MAIN_CMD) main_cnt <= i_slow ? 3 * BUSY_LEN : BUSY_LEN;
            else extra_cnt <= i_slow ? 3 * BUSY_LEN : BUSY_LEN;
            err <= i_err_inj;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- fac_tb.sv ----
/*
  Self-checking bench for fac_ctrl: AXI4-Lite master tasks, random and corner
  commands, a monitor of the device port compared against expected steps.
  Assumes fac_pkg, fac_ctrl and fac_dev_model are compiled first.
*/
`default_nettype none
module tb
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [20:0] fac_log_t [$];
  localparam logic [23:0] BASE = 24'h0F1000;
  localparam int          NBLK = 40;
  logic        clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
  logic [31:0] wdata = 0;
  logic        acc_en = 0, df_mode = 0, cf_mode = 0, tb_busy = 0, slow = 0, err_inj = 0;
  logic [15:0] sec = 0;
  logic        awready, wready, bvalid, arready, rvalid, req, we, ack, mbusy, xbusy, merr, xerr;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  dev_addr;
  logic [15:0] dev_wdata, dev_rdata;
  wire  logic  main_busy_in = mbusy | tb_busy;
  int          err_count = 0, comparisons = 0;
  fac_log_t    seen_q;

  always #12.5 clk = ~clk;

  fac_ctrl #(.DF_BLOCKS(7'd40), .DF_BASE(BASE)) i_dut (.i_clk(clk), .i_nrst(nrst),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_dev_req(req),
    .o_dev_we(we), .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata), .i_dev_ack(ack),
    .i_dev_rdata(dev_rdata), .i_dataflash_access_en(acc_en), .i_df_prog_mode(df_mode),
    .i_cf_prog_mode(cf_mode), .i_main_busy(main_busy_in), .i_extra_busy(xbusy),
    .i_main_err(merr), .i_extra_err(xerr));
  fac_dev_model i_dev (.i_clk(clk), .i_nrst(nrst), .i_req(req), .i_we(we), .i_addr(dev_addr),
    .i_wdata(dev_wdata), .o_ack(ack), .o_rdata(dev_rdata), .o_main_busy(mbusy),
    .o_extra_busy(xbusy), .o_main_err(merr), .o_extra_err(xerr), .i_slow(slow),
    .i_err_inj(err_inj), .i_sec_init(sec));

  always @(posedge clk) begin
    if (req && ack) seen_q.push_back({we, dev_addr, we ? dev_wdata : dev_rdata});
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    @(posedge clk);
  endtask

  function automatic fac_log_t expect_seq(input logic [1:0] op, input logic [23:0] a,
                                          input logic [7:0] d, input logic [15:0] s);
    fac_log_t    q;
    logic [23:0] st;
    logic [23:0] en;
    logic [15:0] mk;
    st = BASE + {a[15:0], 8'h00};
    en = st + BLOCK_LAST;
    mk = 16'h0001 << ((op == OP_ERASE_PROT) ? ERASE_BIT : PROG_BIT);
    q = {};
    if (op == OP_PROG || op == OP_BLANK) q.push_back({1'b1, DEV_AREA_SEL, AREA_USER});
    if (op == OP_PROG) begin
      q.push_back({1'b1, DEV_ADDR_LO, a[15:0]});
      q.push_back({1'b1, DEV_ADDR_HI, 8'h00, a[23:16]});
      q.push_back({1'b1, DEV_WDATA_LO, 8'h00, d});
      q.push_back({1'b1, DEV_MAIN_CMD, CMD_PROGRAM});
    end else if (op == OP_BLANK) begin
      q.push_back({1'b1, DEV_ADDR_LO, st[15:0]});
      q.push_back({1'b1, DEV_ADDR_HI, 8'h00, st[23:16]});
      q.push_back({1'b1, DEV_END_LO, en[15:0]});
      q.push_back({1'b1, DEV_END_HI, 8'h00, en[23:16]});
      q.push_back({1'b1, DEV_MAIN_CMD, CMD_BLANK_DF});
    end else begin
      q.push_back({1'b1, DEV_AREA_SEL, AREA_EXTRA});
      q.push_back({1'b0, DEV_SEC_FLAGS, s});
      q.push_back({1'b1, DEV_WDATA_LO, s & ~mk});
      q.push_back({1'b1, DEV_WDATA_HI, WDATA_HI_ONES});
      q.push_back({1'b1, DEV_EXTRA_CMD, CMD_SECURITY});
    end
    return q;
  endfunction

  task automatic run_op(input logic [1:0] op, input logic [31:0] a, input logic [7:0] d,
                        input logic rf);
    logic [31:0] st;
    logic [1:0]  r;
    fac_log_t    ex;
    int          n;
    seen_q = {};
    axi_wr(REG_ADDR, a, r);
    axi_wr(REG_DATA, {24'h000000, d}, r);
    axi_wr(REG_CMD, {26'h0000000, op, 3'h0, 1'b1}, r);
    chk("bresp_cmd", r, RESP_OKAY);
    n = 0;
    do begin
      axi_rd(REG_STATUS, st, r);
      n++;
    end while (st[ST_DONE_BIT] !== 1'b1 && n < 300);
    chk("done", st[ST_DONE_BIT], 1'b1);
    chk("rresp_status", r, RESP_OKAY);
    if (rf) ex = {};
    else ex = expect_seq(op, a[23:0], d, sec);
    chk("refused", st[ST_REFUSE_BIT], rf);
    chk("dev_error", st[ST_DEVERR_BIT], err_inj & ~rf);
    chk("busy_at_done", {mbusy, xbusy}, 32'h0);
    chk("step_count", seen_q.size(), ex.size());
    for (int i = 0; i < ex.size() && i < seen_q.size(); i++) begin
      chk("dev_step", seen_q[i], ex[i]);
    end
    if (op[1] && !rf) chk("sec_image", st[31:16], sec);
    axi_rd(REG_CMD, st, r);
    chk("cmd_op", st[5:4], op);
    axi_rd(REG_ADDR, st, r);
    chk("addr_reg", st, {8'h00, a[23:0]});
  endtask

  task automatic corner(input logic [1:0] op, input logic [23:0] a, input logic [3:0] m,
                        input logic rf);
    {acc_en, df_mode, cf_mode, tb_busy} <= m;
    err_inj <= 1'b0;
    run_op(op, {8'hC3, a}, 8'hA5, rf);
  endtask

  initial begin
    #(25 * 60000);
    err_count++;
    final_report();
  end

  initial begin
    logic [31:0] st;
    logic [1:0]  r;
    logic [1:0]  op;
    logic [23:0] a;
    void'($urandom(76));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axi_wr(4'h6, 32'h0000_0001, r);
    chk("bresp_unmapped", r, RESP_SLVERR);
    axi_rd(4'h6, st, r);
    chk("rresp_unmapped", r, RESP_SLVERR);
    corner(OP_PROG, BASE, 4'hC, 1'b0);
    corner(OP_PROG, 24'(BASE + NBLK * 256 - 1), 4'hC, 1'b0);
    corner(OP_PROG, 24'(BASE - 24'h000001), 4'hC, 1'b1);
    corner(OP_PROG, 24'(BASE + NBLK * 256), 4'hC, 1'b1);
    corner(OP_BLANK, 24'(NBLK - 1), 4'hC, 1'b0);
    corner(OP_BLANK, 24'(NBLK), 4'hC, 1'b1);
    corner(OP_BLANK, 24'h0, 4'h4, 1'b1);
    corner(OP_PROG, BASE, 4'hA, 1'b1);
    corner(OP_ERASE_PROT, 24'h0, 4'hC, 1'b1);
    corner(OP_PROG, BASE, 4'hD, 1'b1);
    corner(OP_WRITE_PROT, 24'h0, 4'hB, 1'b1);
    for (int k = 0; k < 24; k++) begin
      op = 2'($urandom_range(3, 0));
      if (op == OP_BLANK) a = 24'($urandom_range(NBLK - 1, 0));
      else a = BASE + 24'($urandom_range(NBLK * 256 - 1, 0));
      {acc_en, df_mode, cf_mode, tb_busy} <= {2'b11, op[1], 1'b0} ^ {1'b0, op[1], 2'b00};
      slow <= 1'($urandom_range(1, 0));
      err_inj <= (k % 5 == 4);
      sec <= 16'($urandom);
      run_op(op, {8'($urandom), a}, 8'($urandom), 1'b0);
    end
    final_report();
  end
endmodule
`default_nettype wire
